// ===== bench/scirq_bench.sv
// Purpose: self-checking bench for scirq_top
// Assumes: ce high except in the clock enable test, hready looped from hreadyout
// Notes:   flags seen through irq and pending reads
`timescale 1ns/1ps

module scirq_bench;
    import scirq_pkg::*;
    typedef struct packed {
        logic [7:0] en;
        logic [4:0] ev;
        logic [7:0] ex;
    } scirq_row_t;
    logic        clk, srst, ce, hsel, hwrite, hreadyout, hresp, irq, present, pin;
    logic [31:0] haddr, hwdata, hrdata, r;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    scirq_evt_t  evt;
    int          failures = 0;
    int          numChecks = 0;
    scirq_row_t  rows [7] = '{'{8'hcf, 5'h10, 8'h80}, '{8'hcf, 5'h08, 8'h08}, '{8'hcf, 5'h04, 8'h04},
        '{8'hcf, 5'h02, 8'h02}, '{8'hcf, 5'h01, 8'h01}, '{8'h4e, 5'h1f, 8'h0e}, '{8'hcf, 5'h1f, 8'h8f}};

    scirq_top DUT (.clk(clk), .srst(srst), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .evt(evt), .cardPresentPin(pin), .irq(irq));
    scirq_card_model card (.clk(clk), .present(present), .pin(pin));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // ==========================================================
    // tasks
    task chk(input logic [31:0] s, input logic [31:0] e);
        numChecks++;
        if (s !== e) begin
            failures++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    task report_and_stop;
        $display("checks=%0d failures=%0d", numChecks, failures);
        if (failures == 0 && numChecks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : report_and_stop
    task hwait(output logic [31:0] q);
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (n >= 50) begin
            failures++;
            report_and_stop();
        end
        q = hrdata;
        @(posedge clk);
    endtask : hwait
    task bus(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
        hsel <= 1'b1;
        hwrite <= w;
        haddr <= {20'h0, a};
        htrans <= 2'h2;
        hwait(q);
        htrans <= 2'h0;
        hwdata <= d;
        hwait(q);
    endtask : bus
    task wr(input logic [11:0] a, input logic [31:0] d);
        bus(1'b1, a, d, r);
    endtask : wr
    task rd(input logic [11:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0, r);
        chk(r, e);
        chk({31'h0, hresp}, 32'h0);
    endtask : rd
    task cirq(input logic e);
        @(negedge clk);
        chk({31'h0, irq}, {31'h0, e});
        @(posedge clk);
    endtask : cirq
    // ==========================================================
    // main sequence
    initial begin
        {hsel, hwrite, htrans, haddr, hwdata, evt, present} <= '0;
        hsize <= 3'h2;
        ce <= 1'b1;
        srst <= 1'b1;
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        rd(12'h018, 32'h0);
        rd(12'h01c, 32'h0);
        wr(12'h018, 32'hffff_ffff);
        rd(12'h018, 32'h0000_00cf);
        wr(12'h01c, 32'hffff_ffff);
        rd(12'h01c, 32'h0);
        wr(12'h100, 32'hffff_ffff);
        rd(12'h100, 32'h0);
        rd(12'h030, 32'h0);
        $display("test registers done");
        for (int i = 0; i < 7; i++) begin
            wr(12'h018, {24'h0, rows[i].en});
            evt <= rows[i].ev;
            @(posedge clk);
            evt <= '0;
            cirq(rows[i].ex != 8'h00);
            rd(12'h01c, {24'h0, rows[i].ex});
            rd(12'h01c, 32'h0);
            cirq(1'b0);
        end
        $display("test events done");
        wr(12'h018, 32'h80);
        evt <= 5'h10;
        @(posedge clk);
        rd(12'h01c, 32'h80);
        rd(12'h01c, 32'h80);
        evt <= '0;
        @(posedge clk);
        rd(12'h01c, 32'h80);
        rd(12'h01c, 32'h0);
        $display("test tx empty level done");
        wr(12'h018, 32'h40);
        present <= 1'b1;
        repeat (6) @(posedge clk);
        cirq(1'b1);
        rd(12'h034, 32'h1);
        wr(12'h018, 32'h0);
        cirq(1'b0);
        wr(12'h018, 32'h40);
        cirq(1'b1);
        wr(12'h030, 32'h40);
        cirq(1'b0);
        present <= 1'b0;
        repeat (6) @(posedge clk);
        rd(12'h01c, 32'h40);
        $display("test card done");
        wr(12'h018, 32'hcf);
        evt <= 5'h01;
        @(posedge clk);
        evt <= '0;
        cirq(1'b1);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        cirq(1'b0);
        rd(12'h018, 32'h0);
        rd(12'h01c, 32'h0);
        $display("test mid reset done");
        wr(12'h018, 32'hcf);
        ce <= 1'b0;
        evt <= 5'h01;
        @(posedge clk);
        ce <= 1'b1;
        evt <= '0;
        cirq(1'b0);
        rd(12'h01c, 32'h0);
        $display("test clock enable done");
        report_and_stop();
    end
endmodule : scirq_bench

// ===== bench/scirq_card_model.sv
// Purpose: card contact seen by the interface
// Assumes: bench requests insertion or removal
// Notes:   pin moves just after a clock edge
`timescale 1ns/1ps

module scirq_card_model (
    input  wire logic clk,
    input  wire logic present,
    output logic      pin
);
    initial pin = 1'b0;
    always @(posedge clk) begin
        pin <= present;
    end
endmodule : scirq_card_model

// ===== bench/scirq_checker.sv
// Purpose: port assertions for the smart card interrupt block
// Assumes: one clock, enable register shadowed from bus writes
// Notes:   bound into scirq_top
`timescale 1ns/1ps

module scirq_checker (
    input wire logic                  clk,
    input wire logic                  srst,
    input wire logic                  ce,
    input wire logic                  hsel,
    input wire logic [31:0]           haddr,
    input wire logic [1:0]            htrans,
    input wire logic                  hwrite,
    input wire logic [2:0]            hsize,
    input wire logic [31:0]           hwdata,
    input wire logic                  hready,
    input wire logic                  hreadyout,
    input wire logic                  hresp,
    input wire logic [31:0]           hrdata,
    input wire scirq_pkg::scirq_evt_t evt,
    input wire logic                  cardPresentPin,
    input wire logic                  irq
);
    import scirq_pkg::*;
    logic [7:0] en;
    logic       wPend;
    logic       inData;
    wire        take = hsel && htrans[1] && hready;
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    // ==========================================================
    // shadow of the enable register
    always_ff @(posedge clk) begin
        if (srst) begin
            en <= 8'h00;
            wPend <= 1'b0;
            inData <= 1'b0;
        end else begin
            if (wPend && hreadyout && ce) begin
                en <= hwdata[7:0] & 8'hcf;
            end
            if (hready) begin
                wPend <= take && hwrite && haddr[11:0] == 12'h018;
                inData <= take;
            end
        end
    end
    // ==========================================================
    // assertions
    a_txempty_irq: assert property (evt.txEmpty && en[7] && ce |=> irq)
        else $error("no irq after tx empty");
    a_wait_irq: assert property (evt.waitUnder && en[3] && ce |=> irq)
        else $error("no irq after wait underflow");
    a_txdone_irq: assert property (evt.txDone && en[2] && ce |=> irq)
        else $error("no irq after tx done");
    a_rxdone_irq: assert property (evt.rxDone && en[1] && ce |=> irq)
        else $error("no irq after rx done");
    a_parity_irq: assert property (evt.parity && en[0] && ce |=> irq)
        else $error("no irq after parity fault");
    a_card_irq: assert property ($changed(cardPresentPin) && en[6] && ce ##1 ce[*2] |=> irq)
        else $error("no irq after card change");
    a_masked_quiet: assert property (en == 8'h00 |-> !irq)
        else $error("irq while all enables low");
    a_irq_sticky: assert property (irq && !inData |=> irq)
        else $error("irq dropped without bus access");
    // ==========================================================
    // covers
    c_read_irq: cover property (irq && take && !hwrite);
    c_card: cover property ($changed(cardPresentPin) && en[6]);
    c_all_en: cover property (en == 8'hcf && evt != 5'h00);
endmodule : scirq_checker

bind scirq_top scirq_checker u_chk (.clk(clk), .srst(srst), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .evt(evt),
    .cardPresentPin(cardPresentPin), .irq(irq));

// ===== logic/scirq_ahb_slave.sv
// Purpose: AHB-Lite slave front end, single word transfers
// Assumes: one slave, hready is our own hreadyout
// Notes:   reads take one wait state, writes none while ce is high
`timescale 1ns/1ps
`include "scirq_params.svh"

module scirq_ahb_slave (
    input  wire logic              clk,
    input  wire logic              srst,
    input  wire logic              ce,
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic                   hreadyout,
    output logic                   hresp,
    output logic [31:0]            hrdata,
    output scirq_pkg::scirq_req_t  req,
    input  wire logic [31:0]       rdata
);
    import scirq_pkg::*;

    scirq_bus_st_t            state;
    logic [`SCIRQ_ADDR_W-1:0] addrQ;
    logic                     accept;

    assign accept = hsel && htrans[`SCIRQ_HTRANS_ACT];

    // ==========================================================
    // address phase capture and data phase sequencing
    always_ff @(posedge clk) begin
        if (srst) begin
            state <= SCIRQ_IDLE;
            addrQ <= '0;
        end else if (ce) begin
            if (hready) begin
                if (accept) begin
                    state <= hwrite ? SCIRQ_WR : SCIRQ_RD;
                    addrQ <= haddr[`SCIRQ_ADDR_W-1:0];
                end else begin
                    state <= SCIRQ_IDLE;
                end
            end else if (state == SCIRQ_RD) begin
                state <= SCIRQ_RDDONE;
            end
        end
    end

    always_comb begin
        case (state)
            SCIRQ_RD: hreadyout = 1'b0;
            SCIRQ_WR: hreadyout = ce;
            default:  hreadyout = ce;
        endcase
    end

    assign hresp     = `SCIRQ_HRESP_OKAY;
    assign req.rd    = (state == SCIRQ_RD) && ce;
    assign req.wr    = (state == SCIRQ_WR) && ce;
    assign req.addr  = addrQ;
    assign req.wdata = hwdata;

    // ==========================================================
    // read data held through the completing cycle
    always_ff @(posedge clk) begin
        if (srst) begin
            hrdata <= `SCIRQ_RDATA_RST;
        end else if (req.rd) begin
            hrdata <= rdata;
        end
    end

endmodule : scirq_ahb_slave

// ===== logic/scirq_params.svh
// Purpose: constants of the smart card interrupt enable and pending block
// Assumes: one 40 MHz clock, AHB-Lite register access, byte addressing
// Notes:   offsets are byte addresses within the peripheral window
//
// Contract
// - tx buffer empty raises an interrupt while empty, if enable bit 7 set
// - card insertion or removal raises an interrupt, if enable bit 6 set
// - waiting time counter underflow raises an interrupt, if enable bit 3 set
// - end of character transmission raises an interrupt, if enable bit 2 set
// - end of character reception raises an interrupt, if enable bit 1 set
// - parity error raises an interrupt, if enable bit 0 set
// - a disabled event gives neither pending flag nor interrupt
// - flags set only by hardware; a pending read clears the ones it returned
// - pending bit 7 set when tx buffer empty and enabled
// - pending bit 6 set on card insertion or removal when enabled
// - pending bit 3 set on waiting time underflow when enabled
// - pending bit 2 set after a character is transmitted when enabled
// - pending bit 1 set after a character is received when enabled
// - pending bit 0 set on a parity error when enabled
`ifndef SCIRQ_PARAMS_SVH
`define SCIRQ_PARAMS_SVH

// ==========================================================
// register map
`define SCIRQ_ADDR_W       12
`define SCIRQ_OFS_ENABLE   12'h018
`define SCIRQ_OFS_PENDING  12'h01c
`define SCIRQ_OFS_CLEAR    12'h030
`define SCIRQ_OFS_RAW      12'h034

// ==========================================================
// field layout
`define SCIRQ_FLAG_W       8
`define SCIRQ_BIT_PARITY   0
`define SCIRQ_BIT_RXDONE   1
`define SCIRQ_BIT_TXDONE   2
`define SCIRQ_BIT_WAIT     3
`define SCIRQ_BIT_CARD     6
`define SCIRQ_BIT_TXEMPTY  7
`define SCIRQ_FLAG_MASK    8'hcf
`define SCIRQ_RAW_CARD     0
`define SCIRQ_RAW_TXEMPTY  1

// ==========================================================
// reset values
`define SCIRQ_ENABLE_RST   8'h00
`define SCIRQ_PENDING_RST  8'h00
`define SCIRQ_RDATA_RST    32'h0000_0000

// ==========================================================
// bus encodings
`define SCIRQ_HTRANS_ACT   1
`define SCIRQ_HRESP_OKAY   1'b0

`endif

// ===== logic/scirq_pkg.sv
// Purpose: types shared by the smart card interrupt block
// Assumes: scirq_params.svh gives the widths
// Notes:   none
`include "scirq_params.svh"

package scirq_pkg;

    // ==========================================================
    // flag vector and register request
    typedef logic [`SCIRQ_FLAG_W-1:0] scirq_flags_t;

    typedef struct packed {
        logic                     rd;
        logic                     wr;
        logic [`SCIRQ_ADDR_W-1:0] addr;
        logic [31:0]              wdata;
    } scirq_req_t;

    // ==========================================================
    // event sources, all on clk except card presence
    typedef struct packed {
        logic txEmpty;
        logic waitUnder;
        logic txDone;
        logic rxDone;
        logic parity;
    } scirq_evt_t;

    // ==========================================================
    // bus slave states, gray along idle-read-done
    typedef enum logic [1:0] {
        SCIRQ_IDLE   = 2'b00,
        SCIRQ_RD     = 2'b01,
        SCIRQ_RDDONE = 2'b11,
        SCIRQ_WR     = 2'b10
    } scirq_bus_st_t;

endpackage : scirq_pkg

// ===== logic/scirq_sync2.sv
// Purpose: two flip-flop synchroniser for pin levels
// Assumes: input is asynchronous to clk
// Notes:   first stage feeds only the second
`timescale 1ns/1ps

module scirq_sync2 #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         srst,
    input  wire logic         ce,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    import scirq_pkg::*;

    logic [W-1:0] stage1;

    always_ff @(posedge clk) begin
        if (srst) begin
            stage1 <= '0;
            dout   <= '0;
        end else if (ce) begin
            stage1 <= din;
            dout   <= stage1;
        end
    end

endmodule : scirq_sync2

// ===== logic/scirq_top.sv
// Purpose: interrupt enable and pending flags of the smart card interface
// Assumes: event inputs come from logic on clk; card presence is a pin
// Notes:   pending clears on read and through the clear register
//
// Decided for this implementation: the AHB-Lite slave port.
`timescale 1ns/1ps
`include "scirq_params.svh"

module scirq_top (
    input  wire logic                   clk,
    input  wire logic                   srst,
    input  wire logic                   ce,
    input  wire logic                   hsel,
    input  wire logic [31:0]            haddr,
    input  wire logic [1:0]             htrans,
    input  wire logic                   hwrite,
    input  wire logic [2:0]             hsize,
    input  wire logic [31:0]            hwdata,
    input  wire logic                   hready,
    output logic                        hreadyout,
    output logic                        hresp,
    output logic [31:0]                 hrdata,
    input  wire scirq_pkg::scirq_evt_t  evt,
    input  wire logic                   cardPresentPin,
    output logic                        irq
);
    import scirq_pkg::*;

    localparam scirq_flags_t FlagMask = `SCIRQ_FLAG_MASK;
    localparam scirq_flags_t PendRst  = `SCIRQ_PENDING_RST;

    scirq_req_t   req;
    logic [31:0]  rdata;
    logic         cardPresent;
    logic         cardPresentQ;
    logic         cardChange;
    scirq_flags_t raw;
    scirq_flags_t enable;
    scirq_flags_t pending;
    scirq_flags_t rdClear;
    scirq_flags_t wrClear;
    logic         selEnable;
    logic         selPending;
    logic         selClear;
    logic         selRaw;

    // ==========================================================
    // bus front end
    scirq_ahb_slave u_bus (
        .clk       (clk),
        .srst      (srst),
        .ce        (ce),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hsize     (hsize),
        .hwdata    (hwdata),
        .hready    (hready),
        .hreadyout (hreadyout),
        .hresp     (hresp),
        .hrdata    (hrdata),
        .req       (req),
        .rdata     (rdata)
    );

    // ==========================================================
    // card presence pin and its change detector
    scirq_sync2 #(
        .W (1)
    ) u_card_sync (
        .clk  (clk),
        .srst (srst),
        .ce   (ce),
        .din  (cardPresentPin),
        .dout (cardPresent)
    );

    always_ff @(posedge clk) begin
        if (srst) begin
            cardPresentQ <= 1'b0;
        end else if (ce) begin
            cardPresentQ <= cardPresent;
        end
    end

    // either edge counts: insertion or removal
    assign cardChange = cardPresent ^ cardPresentQ;

    // ==========================================================
    // event vector in pending layout
    always_comb begin
        raw                     = '0;
        raw[`SCIRQ_BIT_TXEMPTY] = evt.txEmpty;
        raw[`SCIRQ_BIT_CARD]    = cardChange;
        raw[`SCIRQ_BIT_WAIT]    = evt.waitUnder;
        raw[`SCIRQ_BIT_TXDONE]  = evt.txDone;
        raw[`SCIRQ_BIT_RXDONE]  = evt.rxDone;
        raw[`SCIRQ_BIT_PARITY]  = evt.parity;
    end

    // ==========================================================
    // address decode
    always_comb begin
        selEnable  = 1'b0;
        selPending = 1'b0;
        selClear   = 1'b0;
        selRaw     = 1'b0;
        if (req.addr == `SCIRQ_OFS_ENABLE) begin
            selEnable = 1'b1;
        end else if (req.addr == `SCIRQ_OFS_PENDING) begin
            selPending = 1'b1;
        end else if (req.addr == `SCIRQ_OFS_CLEAR) begin
            selClear = 1'b1;
        end else if (req.addr == `SCIRQ_OFS_RAW) begin
            selRaw = 1'b1;
        end
    end

    // ==========================================================
    // enable register
    always_ff @(posedge clk) begin
        if (srst) begin
            enable <= `SCIRQ_ENABLE_RST;
        end else if (req.wr && selEnable) begin
            enable <= req.wdata[`SCIRQ_FLAG_W-1:0] & FlagMask;
        end
    end

    // ==========================================================
    // clear sources: read returns then clears, clear register
    assign rdClear = (req.rd && selPending) ? pending : '0;
    assign wrClear = (req.wr && selClear) ? req.wdata[`SCIRQ_FLAG_W-1:0] : '0;

    // ==========================================================
    // sticky pending flags, set wins over clear
    for (genvar i = 0; i < `SCIRQ_FLAG_W; i++) begin : g_flag
        if (FlagMask[i]) begin : g_impl
            always_ff @(posedge clk) begin
                if (srst) begin
                    pending[i] <= PendRst[i];
                end else if (ce) begin
                    if (raw[i] && enable[i]) begin
                        pending[i] <= 1'b1;
                    end else if (rdClear[i] || wrClear[i]) begin
                        pending[i] <= 1'b0;
                    end
                end
            end
        end else begin : g_rsvd
            assign pending[i] = 1'b0;
        end
    end

    // ==========================================================
    // read data
    always_comb begin
        rdata = '0;
        if (selEnable) begin
            rdata[`SCIRQ_FLAG_W-1:0] = enable;
        end else if (selPending) begin
            rdata[`SCIRQ_FLAG_W-1:0] = pending;
        end else if (selRaw) begin
            rdata[`SCIRQ_RAW_CARD]    = cardPresent;
            rdata[`SCIRQ_RAW_TXEMPTY] = evt.txEmpty;
        end
    end

    // ==========================================================
    // interrupt line
    assign irq = |(pending & enable);

endmodule : scirq_top
